// file: design/radio_config_status_regs.sv
// Configuration and status register bank of the radio transceiver
// Summary of operation
// - Bit 6 of each pin config register inverts that pin's selected signal
// - Pin 2 signal select resets to the chip-ready code 0x29
// - Pin 1 signal select resets to the three-state code 0x2e
// - Pin 0 signal select resets to crystal clock divided by 192, 0x3f
// - Pin 1 config bit 7 sets drive strength for all pins, reset low
// - Threshold exceeded when FIFO byte count is at or above threshold
// - TX threshold 61-4n, RX threshold 4(n+1); reset setting 7
// - Sync word is high byte then low byte, reset 0xd3 and 0x91
// - Frame size register, reset 255: fixed length or maximum length
// - TX fill status gives underflow flag and TX FIFO byte count
// - RX fill status gives overflow flag and RX FIFO byte count
// - Status 0x35 returns radio control state machine state
// - Wake timer readable as high byte 0x36 and low byte 0x37
// - Status 0x38 returns output pin levels and packet status
// - Status 0x34 returns signal strength, 0x33 link quality
`timescale 1ns/10ps

module radio_config_status_regs
	import radio_regs_pkg::*;
#(
	parameter logic [7:0] PART_ID  = 8'h5a,	// Arbitrary value
	parameter logic [7:0] REVISION = 8'h01	// Arbitrary value
)
(
	// Clock and reset
	input  wire logic                MCLK_I,
	input  wire logic                RST_N_I,
	// Host register port
	input  wire logic                REG_WR_I,
	input  wire logic                REG_RD_I,
	input  wire logic [ADDR_W-1:0]   REG_ADDR_I,
	input  wire logic [DATA_W-1:0]   REG_WDATA_I,
	output logic      [DATA_W-1:0]   REG_RDATA_O,
	output logic                     REG_RVALID_O,
	// Status sources from the radio core
	input  wire logic [7:0]          FREQ_EST_I,
	input  wire logic [7:0]          LINK_QUAL_I,
	input  wire logic [7:0]          SIG_STRENGTH_I,
	input  wire logic [4:0]          FSM_STATE_I,
	input  wire logic [15:0]         WAKE_TIMER_I,
	input  wire logic [4:0]          FRAME_STATUS_I,
	input  wire logic [7:0]          SYNTH_CAL_I,
	input  wire logic                TX_UNDERFLOW_I,
	input  wire logic [6:0]          TX_FILL_I,
	input  wire logic                RX_OVERFLOW_I,
	input  wire logic [6:0]          RX_FILL_I,
	// Raw output pin signals chosen by the selects
	input  wire logic [2:0]          PIN_SIGNAL_I,
	// Configuration outputs
	output logic [5:0]               PIN2_SIGNAL_SELECT_O,
	output logic [5:0]               PIN1_SIGNAL_SELECT_O,
	output logic [5:0]               PIN0_SIGNAL_SELECT_O,
	output logic                     PIN_DRIVE_STRENGTH_O,
	output logic                     TEMP_SENSOR_EN_O,
	output logic [15:0]              SYNC_WORD_O,
	output logic [7:0]               FRAME_SIZE_O,
	// Pin levels and threshold flags
	output logic [2:0]               GP_OUT_PINS_O,
	output logic                     TX_THR_EXCEEDED_O,
	output logic                     RX_THR_EXCEEDED_O
);
	import radio_regs_pkg::*;

	logic           rst_sync_word_high_reg;
	logic           rst_sync2_reg;
	logic           rst_n;
	logic [7:0]     pin2_cfg_reg;
	logic [7:0]     pin1_cfg_reg;
	logic [7:0]     pin0_cfg_reg;
	logic [3:0]     thr_setting_reg;
	logic [7:0]     sync_high_reg;
	logic [7:0]     sync_low_reg;
	logic [7:0]     frame_size_reg;
	logic [6:0]     tx_thr;
	logic [6:0]     rx_thr;
	logic [2:0]     pin_levels;
	logic [7:0]     rdata_next;
	port_state_type state_reg;

	// Reset release through two flops
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rst_sync_word_high_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end
		else
		begin
			rst_sync_word_high_reg <= 1'b1;
			rst_sync2_reg <= rst_sync_word_high_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// Writes only reach the configuration block; status offsets are dropped
	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin2_cfg_reg    <= RST_PIN2_CFG;
			pin1_cfg_reg    <= RST_PIN1_CFG;
			pin0_cfg_reg    <= RST_PIN0_CFG;
			thr_setting_reg <= RST_BUFFER_THRESHOLD_SETTING;
			sync_high_reg   <= RST_SYNC_HIGH;
			sync_low_reg    <= RST_SYNC_LOW;
			frame_size_reg  <= RST_FRAME_SIZE;
		end
		else if (REG_WR_I)
		begin
			case (REG_ADDR_I)
				// Bit 7 of pin 2 is reserved and stays clear
				OFS_PIN2_CFG:   pin2_cfg_reg <= {1'b0, REG_WDATA_I[6:0]};
				OFS_PIN1_CFG:   pin1_cfg_reg <= REG_WDATA_I;
				OFS_PIN0_CFG:   pin0_cfg_reg <= REG_WDATA_I;
				OFS_BUFFER_THRESHOLD_SETTING:   thr_setting_reg <= REG_WDATA_I[3:0];
				OFS_SYNC_HIGH:  sync_high_reg <= REG_WDATA_I;
				OFS_SYNC_LOW:   sync_low_reg <= REG_WDATA_I;
				OFS_FRAME_SIZE: frame_size_reg <= REG_WDATA_I;
				default:        ;
			endcase
		end
	end

	// Thresholds from the four-bit setting
	assign tx_thr = TX_THR_BASE - {thr_setting_reg, 2'b00};
	assign rx_thr = {1'b0, thr_setting_reg, 2'b00} + THR_STEP;

	// Each pin's raw signal passes through its invert bit
	assign pin_levels = PIN_SIGNAL_I ^ {pin2_cfg_reg[POS_INVERT],
		pin1_cfg_reg[POS_INVERT], pin0_cfg_reg[POS_INVERT]};

	// Status and config readback mux
	always_comb
	begin
		rdata_next = 8'h00;
		case (REG_ADDR_I)
			OFS_PIN2_CFG:   rdata_next = pin2_cfg_reg;
			OFS_PIN1_CFG:   rdata_next = pin1_cfg_reg;
			OFS_PIN0_CFG:   rdata_next = pin0_cfg_reg;
			OFS_BUFFER_THRESHOLD_SETTING:   rdata_next = {4'h0, thr_setting_reg};
			OFS_SYNC_HIGH:  rdata_next = sync_high_reg;
			OFS_SYNC_LOW:   rdata_next = sync_low_reg;
			OFS_FRAME_SIZE: rdata_next = frame_size_reg;
			OFS_PART_ID:    rdata_next = PART_ID;
			OFS_REVISION:   rdata_next = REVISION;
			OFS_FREQ_EST:   rdata_next = FREQ_EST_I;
			OFS_LINK_QUAL:  rdata_next = LINK_QUAL_I;
			OFS_SIG_STRG:   rdata_next = SIG_STRENGTH_I;
			OFS_FSM_STATE:  rdata_next = {3'h0, FSM_STATE_I};
			OFS_WAKE_HIGH:  rdata_next = WAKE_TIMER_I[15:8];
			OFS_WAKE_LOW:   rdata_next = WAKE_TIMER_I[7:0];
			OFS_PIN_FRAME:  rdata_next = {pin_levels, FRAME_STATUS_I};
			OFS_SYNTH_CAL:  rdata_next = SYNTH_CAL_I;
			OFS_TX_FILL:    rdata_next = {TX_UNDERFLOW_I, TX_FILL_I};
			OFS_RX_FILL:    rdata_next = {RX_OVERFLOW_I, RX_FILL_I};
			default:        rdata_next = 8'h00;
		endcase
	end

	// Access tracker; a read only samples, so no source is disturbed
	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= ST_IDLE;
		else if (REG_RD_I)
			state_reg <= ST_READ;
		else if (REG_WR_I)
			state_reg <= ST_WRITE;
		else
			state_reg <= ST_IDLE;
	end

	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			REG_RDATA_O  <= 8'h00;
			REG_RVALID_O <= 1'b0;
		end
		else
		begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I)
				REG_RDATA_O <= rdata_next;
		end
	end

	// Registered configuration and pin outputs
	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			PIN2_SIGNAL_SELECT_O <= RST_PIN2_CFG[5:0];
			PIN1_SIGNAL_SELECT_O <= RST_PIN1_CFG[5:0];
			PIN0_SIGNAL_SELECT_O <= RST_PIN0_CFG[5:0];
			PIN_DRIVE_STRENGTH_O <= 1'b0;
			TEMP_SENSOR_EN_O     <= 1'b0;
			SYNC_WORD_O          <= {RST_SYNC_HIGH, RST_SYNC_LOW};
			FRAME_SIZE_O         <= RST_FRAME_SIZE;
			GP_OUT_PINS_O        <= 3'h0;
			TX_THR_EXCEEDED_O    <= 1'b0;
			RX_THR_EXCEEDED_O    <= 1'b0;
		end
		else
		begin
			PIN2_SIGNAL_SELECT_O <= pin2_cfg_reg[5:0];
			PIN1_SIGNAL_SELECT_O <= pin1_cfg_reg[5:0];
			PIN0_SIGNAL_SELECT_O <= pin0_cfg_reg[5:0];
			PIN_DRIVE_STRENGTH_O <= pin1_cfg_reg[POS_DRIVE];
			TEMP_SENSOR_EN_O     <= pin0_cfg_reg[POS_TEMP_EN];
			SYNC_WORD_O          <= {sync_high_reg, sync_low_reg};
			FRAME_SIZE_O         <= frame_size_reg;
			GP_OUT_PINS_O        <= pin_levels;
			TX_THR_EXCEEDED_O    <= (TX_FILL_I >= tx_thr);
			RX_THR_EXCEEDED_O    <= (RX_FILL_I >= rx_thr);
		end
	end

	// Checks
	sequence s_write_cfg(logic [5:0] a);
		REG_WR_I && !REG_RD_I && REG_ADDR_I == a;
	endsequence

	a_pin_invert: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		GP_OUT_PINS_O[0] == $past(PIN_SIGNAL_I[0] ^ pin0_cfg_reg[6]))
		else $error("pin 0 level not inverted as configured");
	a_pin2_reset: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		$rose(rst_n) |-> pin2_cfg_reg == 8'h29)
		else $error("pin 2 select reset wrong");
	a_pin1_reset: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		$rose(rst_n) |-> pin1_cfg_reg == 8'h2e)
		else $error("pin 1 select reset wrong");
	a_pin0_reset: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		$rose(rst_n) |-> pin0_cfg_reg == 8'h3f)
		else $error("pin 0 select reset wrong");
	a_drive_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_write_cfg(6'h01) |=> ##1
		PIN_DRIVE_STRENGTH_O == $past(REG_WDATA_I[7], 2))
		else $error("drive strength did not follow write");
	a_tx_thr_flag: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		TX_THR_EXCEEDED_O == ($past(TX_FILL_I) >= 7'd61 - 7'(4*$past(thr_setting_reg))))
		else $error("tx threshold flag wrong");
	a_rx_thr_flag: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		RX_THR_EXCEEDED_O == ($past(RX_FILL_I) >= 7'(4*($past(thr_setting_reg)+1))))
		else $error("rx threshold flag wrong");
	a_thr_upper_zero: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		REG_RD_I && REG_ADDR_I == 6'h03 |=> REG_RVALID_O && REG_RDATA_O[7:4] == 4'h0)
		else $error("threshold reserved bits not zero");
	a_sync_word: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_write_cfg(6'h04) |=> ##1 SYNC_WORD_O[15:8] == $past(REG_WDATA_I, 2))
		else $error("sync high byte not applied");
	a_tx_fill_read: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		REG_RD_I && REG_ADDR_I == 6'h3a |=> REG_RDATA_O == $past({TX_UNDERFLOW_I, TX_FILL_I}))
		else $error("tx fill status read wrong");
	a_status_ro: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		REG_WR_I && REG_ADDR_I >= 6'h30 |=> $stable(frame_size_reg) && $stable(pin0_cfg_reg))
		else $error("status write changed config");

	// Read request at one address, answered one edge later
	sequence s_read_at(logic [5:0] a);
		REG_RD_I && REG_ADDR_I == a;
	endsequence

	a_pin1_invert: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		GP_OUT_PINS_O[1] == $past(PIN_SIGNAL_I[1] ^ pin1_cfg_reg[6]))
		else $error("pin 1 level not inverted as configured");

	a_pin2_invert: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		GP_OUT_PINS_O[2] == $past(PIN_SIGNAL_I[2] ^ pin2_cfg_reg[6]))
		else $error("pin 2 level not inverted as configured");

	// Reserved top bit of pin 2 must never be stored
	a_pin2_reserved: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		pin2_cfg_reg[7] == 1'b0)
		else $error("pin 2 reserved bit set");

	a_sel2_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		PIN2_SIGNAL_SELECT_O == $past(pin2_cfg_reg[5:0]))
		else $error("pin 2 select output stale");

	a_sel1_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		PIN1_SIGNAL_SELECT_O == $past(pin1_cfg_reg[5:0]))
		else $error("pin 1 select output stale");

	a_sel0_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		PIN0_SIGNAL_SELECT_O == $past(pin0_cfg_reg[5:0]))
		else $error("pin 0 select output stale");

	a_temp_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		TEMP_SENSOR_EN_O == $past(pin0_cfg_reg[7]))
		else $error("temperature enable output stale");

	a_thr_reset: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		$rose(rst_n) |-> thr_setting_reg == 4'h7)
		else $error("threshold setting reset wrong");

	a_thr_write: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_write_cfg(6'h03) |=> thr_setting_reg == $past(REG_WDATA_I[3:0]))
		else $error("threshold setting not written");

	a_sync_reset: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		$rose(rst_n) |-> sync_high_reg == 8'hd3 && sync_low_reg == 8'h91)
		else $error("sync word reset wrong");

	a_sync_low: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_write_cfg(6'h05) |=> ##1 SYNC_WORD_O[7:0] == $past(REG_WDATA_I, 2))
		else $error("sync low byte not applied");

	a_size_reset: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		$rose(rst_n) |-> frame_size_reg == 8'hff)
		else $error("frame size reset wrong");

	a_size_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_write_cfg(6'h06) |=> ##1 FRAME_SIZE_O == $past(REG_WDATA_I, 2))
		else $error("frame size not applied");

	a_rx_fill_read: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h3b) |=> REG_RDATA_O == $past({RX_OVERFLOW_I, RX_FILL_I}))
		else $error("rx fill status read wrong");

	a_fsm_read: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h35) |=> REG_RDATA_O == {3'h0, $past(FSM_STATE_I)})
		else $error("state machine read wrong");

	a_wake_high: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h36) |=> REG_RDATA_O == $past(WAKE_TIMER_I[15:8]))
		else $error("wake timer high read wrong");

	a_wake_low: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h37) |=> REG_RDATA_O == $past(WAKE_TIMER_I[7:0]))
		else $error("wake timer low read wrong");

	a_frame_read: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h38) |=> REG_RDATA_O[4:0] == $past(FRAME_STATUS_I))
		else $error("packet status read wrong");

	a_strength_read: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h34) |=> REG_RDATA_O == $past(SIG_STRENGTH_I))
		else $error("signal strength read wrong");

	a_quality_read: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h33) |=> REG_RDATA_O == $past(LINK_QUAL_I))
		else $error("link quality read wrong");

	a_part_read: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		s_read_at(6'h30) |=> REG_RDATA_O == PART_ID)
		else $error("part id read wrong");

	// Gap between config and status must read as zero
	a_unmapped_zero: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		REG_RD_I && REG_ADDR_I >= 6'h07 && REG_ADDR_I < 6'h30
		|=> REG_RDATA_O == 8'h00)
		else $error("unmapped read not zero");

	a_read_no_side: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		REG_RD_I && !REG_WR_I |=> $stable(pin0_cfg_reg)
		&& $stable(thr_setting_reg) && $stable(sync_high_reg))
		else $error("read disturbed configuration");

	a_rvalid_track: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		REG_RVALID_O == (state_reg == ST_READ))
		else $error("read valid disagrees with tracker");

	// Host may pick up read data late, so it must hold
	a_rdata_hold: assert property (@(posedge MCLK_I) disable iff (!rst_n)
		!REG_RD_I |=> $stable(REG_RDATA_O))
		else $error("read data changed without read");

endmodule

// file: design/radio_regs_pkg.sv
// Register map, field positions and reset values for the radio register bank
package radio_regs_pkg;

	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// Configuration register offsets
	localparam logic [5:0] OFS_PIN2_CFG   = 6'h00;
	localparam logic [5:0] OFS_PIN1_CFG   = 6'h01;
	localparam logic [5:0] OFS_PIN0_CFG   = 6'h02;
	localparam logic [5:0] OFS_BUFFER_THRESHOLD_SETTING   = 6'h03;
	localparam logic [5:0] OFS_SYNC_HIGH  = 6'h04;
	localparam logic [5:0] OFS_SYNC_LOW   = 6'h05;
	localparam logic [5:0] OFS_FRAME_SIZE = 6'h06;

	// Status register offsets
	localparam logic [5:0] OFS_PART_ID    = 6'h30;
	localparam logic [5:0] OFS_REVISION   = 6'h31;
	localparam logic [5:0] OFS_FREQ_EST   = 6'h32;
	localparam logic [5:0] OFS_LINK_QUAL  = 6'h33;
	localparam logic [5:0] OFS_SIG_STRG   = 6'h34;
	localparam logic [5:0] OFS_FSM_STATE  = 6'h35;
	localparam logic [5:0] OFS_WAKE_HIGH  = 6'h36;
	localparam logic [5:0] OFS_WAKE_LOW   = 6'h37;
	localparam logic [5:0] OFS_PIN_FRAME  = 6'h38;
	localparam logic [5:0] OFS_SYNTH_CAL  = 6'h39;
	localparam logic [5:0] OFS_TX_FILL    = 6'h3a;
	localparam logic [5:0] OFS_RX_FILL    = 6'h3b;

	// Field positions
	localparam int POS_INVERT   = 6;
	localparam int POS_DRIVE    = 7;
	localparam int POS_TEMP_EN  = 7;
	localparam int POS_FLOW_ERR = 7;

	// Reset values
	localparam logic [7:0] RST_PIN2_CFG   = 8'h29;
	localparam logic [7:0] RST_PIN1_CFG   = 8'h2e;
	localparam logic [7:0] RST_PIN0_CFG   = 8'h3f;
	localparam logic [3:0] RST_BUFFER_THRESHOLD_SETTING   = 4'h7;
	localparam logic [7:0] RST_SYNC_HIGH  = 8'hd3;
	localparam logic [7:0] RST_SYNC_LOW   = 8'h91;
	localparam logic [7:0] RST_FRAME_SIZE = 8'hff;

	// Threshold arithmetic: tx = 61 - 4n, rx = 4(n+1)
	localparam logic [6:0] TX_THR_BASE = 7'h3d;
	localparam logic [6:0] THR_STEP    = 7'h04;

	// Host port access states
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ  = 2'b11
	} port_state_type;

endpackage

// file: tb/host_model.sv
// Host model speaking the register port of the radio register bank
`timescale 1ns/10ps
module host_model
	import radio_regs_pkg::*;
(
	input  wire logic              clk_i,
	output logic                   wr_o,
	output logic                   rd_o,
	output logic [ADDR_W-1:0]      addr_o,
	output logic [DATA_W-1:0]      wdata_o,
	input  wire logic [DATA_W-1:0] rdata_i,
	input  wire logic              rvalid_i
);
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 6'h00;
		wdata_o = 8'h00;
	end
	task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == OFS_BUFFER_THRESHOLD_SETTING)
			v[7:4] = 4'h0;
		if (a == OFS_PIN0_CFG && d[POS_TEMP_EN])
			v = 8'h80;
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// Released data never repeats its last value
		wdata_o <= ~v;
	endtask
	task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
	endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the radio register bank
`timescale 1ns/10ps
module tb_top;
	import radio_regs_pkg::*;
	logic        clk, rst_n, wr, rd, rvalid, tx_un, rx_ov, drv, temp;
	logic        tx_thr, rx_thr;
	logic [5:0]  addr, sel2, sel1, sel0;
	logic [7:0]  wdata, rdata, f_est, lq, ss, synth, fsize;
	logic [4:0]  fsm, fstat;
	logic [15:0] wake, sync;
	logic [6:0]  tx_fill, rx_fill;
	logic [2:0]  pin_sig, gp;
	int          err_total, checks, cycles;

	host_model HOST (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
	// Identity values are arbitrary
	radio_config_status_regs #(.PART_ID(8'hc3), .REVISION(8'h02)) DUT (
		.MCLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
		.REG_RVALID_O(rvalid), .FREQ_EST_I(f_est), .LINK_QUAL_I(lq),
		.SIG_STRENGTH_I(ss), .FSM_STATE_I(fsm), .WAKE_TIMER_I(wake),
		.FRAME_STATUS_I(fstat), .SYNTH_CAL_I(synth),
		.TX_UNDERFLOW_I(tx_un), .TX_FILL_I(tx_fill),
		.RX_OVERFLOW_I(rx_ov), .RX_FILL_I(rx_fill),
		.PIN_SIGNAL_I(pin_sig), .PIN2_SIGNAL_SELECT_O(sel2),
		.PIN1_SIGNAL_SELECT_O(sel1), .PIN0_SIGNAL_SELECT_O(sel0),
		.PIN_DRIVE_STRENGTH_O(drv), .TEMP_SENSOR_EN_O(temp),
		.SYNC_WORD_O(sync), .FRAME_SIZE_O(fsize), .GP_OUT_PINS_O(gp),
		.TX_THR_EXCEEDED_O(tx_thr), .RX_THR_EXCEEDED_O(rx_thr));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] d;
		HOST.read_reg(a, d);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
	endtask
	// Config outputs trail the write by one edge
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			close_out;
		end
	end
	initial
	begin
		{rst_n, f_est, lq, ss, fsm, wake, fstat, synth} = '0;
		{tx_un, tx_fill, rx_ov, rx_fill, pin_sig} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("sel2", 16'h29, sel2);
		chk("sel1", 16'h2e, sel1);
		chk("sel0", 16'h3f, sel0);
		chk("drive", 16'h0, drv);
		chk("sync", 16'hd391, sync);
		chk("size", 16'hff, fsize);
		rchk(6'h00, 8'h29);
		rchk(6'h01, 8'h2e);
		rchk(6'h02, 8'h3f);
		rchk(6'h03, 8'h07);
		rchk(6'h04, 8'hd3);
		rchk(6'h05, 8'h91);
		rchk(6'h06, 8'hff);
		$display("test reset values done");
		pin_sig <= 3'b101;
		HOST.write_reg(6'h00, 8'h40);
		HOST.write_reg(6'h01, 8'h81);
		HOST.write_reg(6'h02, 8'h80);
		settle;
		chk("pins", 16'h1, gp);
		chk("drive", 16'h1, drv);
		chk("sel1", 16'h01, sel1);
		chk("temp", 16'h1, temp);
		chk("sel2", 16'h00, sel2);
		HOST.write_reg(6'h02, 8'h7f);
		settle;
		chk("sel0", 16'h3f, sel0);
		chk("pins", 16'h0, gp);
		chk("temp", 16'h0, temp);
		$display("test pin config done");
		for (int n = 0; n < 16; n++)
		begin
			HOST.write_reg(6'h03, {4'hf, n[3:0]});
			tx_fill <= 7'(61 - 4 * n);
			rx_fill <= 7'(4 * n + 3);
			settle;
			chk("tx thr", 16'h1, tx_thr);
			chk("rx thr", 16'h0, rx_thr);
			@(posedge clk);
			tx_fill <= 7'(60 - 4 * n);
			rx_fill <= 7'(4 * n + 4);
			settle;
			chk("tx thr", 16'h0, tx_thr);
			chk("rx thr", 16'h1, rx_thr);
		end
		rchk(6'h03, 8'h0f);
		HOST.write_reg(6'h04, 8'ha5);
		HOST.write_reg(6'h05, 8'h3c);
		HOST.write_reg(6'h06, 8'h20);
		settle;
		chk("sync", 16'ha53c, sync);
		chk("size", 16'h20, fsize);
		$display("test threshold and sync done");
		@(posedge clk);
		{f_est, lq, ss, fsm, wake} <= {24'h123456, 5'h0d, 16'hbeef};
		{fstat, synth, tx_un, tx_fill} <= {5'h15, 8'h9a, 8'haa};
		{rx_ov, rx_fill} <= 8'hc0;
		rchk(6'h30, 8'hc3);
		rchk(6'h31, 8'h02);
		rchk(6'h32, 8'h12);
		rchk(6'h33, 8'h34);
		rchk(6'h34, 8'h56);
		rchk(6'h35, 8'h0d);
		rchk(6'h36, 8'hbe);
		rchk(6'h37, 8'hef);
		rchk(6'h38, 8'h15);
		rchk(6'h39, 8'h9a);
		rchk(6'h3a, 8'haa);
		rchk(6'h3b, 8'hc0);
		HOST.write_reg(6'h35, 8'hff);
		rchk(6'h35, 8'h0d);
		rchk(6'h3a, 8'haa);
		rchk(6'h07, 8'h00);
		$display("test status registers done");
		close_out;
	end
endmodule
